// file: design/wake_timer_consts.vh
`ifndef WAKE_TIMER_CONSTS_VH
`define WAKE_TIMER_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_RELOAD 8'h86
`define OFF_CONTROL 8'h8F
`define OFF_IRQ_CONTROL 8'h90
`define OFF_STATUS 8'h91
`define OFF_MASK 8'h92
`define OFF_COUNT 8'h93

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTL_FLAG_BIT 4
`define CTL_RUN_BIT 3
`define CTL_PS_MSB 2
`define CTL_PS_LSB 0
`define IEN_WAKE_BIT 0
`define IEN_GLOBAL_BIT 1
`define EVT_OVERFLOW_BIT 0
`define EVT_WAKEUP_BIT 1
`define EVT_WIDTH 2

// ----------------------------------------
// Reset values and counter top
// ----------------------------------------
`define RST_CONTROL 8'h00
`define RST_RELOAD 8'h00
`define RST_IRQ_CONTROL 2'h0
`define RST_STATUS 2'h0
`define RST_MASK 2'h0
`define RST_COUNT 8'h00
`define COUNT_TOP 8'hFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define OSC_FREQ_HZ 10000
`define SYS_FREQ_HZ 100000000
`define MIN_CLOCK_RATIO 2
`define PS_WIDTH 11

`endif

// file: design/osc_edge_sync.v
`timescale 1ns/100ps
`include "wake_timer_consts.vh"

// ----------------------------------------
// Low-speed oscillator edge detector
// ----------------------------------------
module osc_edge_sync (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Oscillator pin and tick
    input wire osc_in,
    output reg osc_tick
);

    reg sync_a;
    reg sync_b;
    reg sync_c;
    reg osc_level;

    always @(posedge sys_clk) begin
        if (reset) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
            osc_level <= 1'b0;
            osc_tick <= 1'b0;
        end else begin
            sync_a <= osc_in;
            sync_b <= sync_a;
            sync_c <= sync_b;
            osc_tick <= 1'b0;
            // A change counts only once the two later stages agree
            if (sync_b == sync_c && sync_b != osc_level) begin
                osc_level <= sync_b;
                osc_tick <= sync_b;
            end
        end
    end

endmodule

// file: design/wake_prescaler.v
`timescale 1ns/100ps
`include "wake_timer_consts.vh"

// ----------------------------------------
// Oscillator tick prescaler
// ----------------------------------------
module wake_prescaler (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Control
    input wire clear,
    input wire osc_tick,
    input wire [2:0] select,
    // Prescaled tick
    output wire ps_tick
);

    reg [`PS_WIDTH-1:0] count;

    function [`PS_WIDTH-1:0] last_count;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: last_count = 11'h000;
                3'h1: last_count = 11'h003;
                3'h2: last_count = 11'h00F;
                3'h3: last_count = 11'h03F;
                3'h4: last_count = 11'h0FF;
                3'h5: last_count = 11'h1FF;
                3'h6: last_count = 11'h3FF;
                default: last_count = 11'h7FF;
            endcase
        end
    endfunction

    assign ps_tick = osc_tick & (count >= last_count(select));

    always @(posedge sys_clk) begin
        if (reset || clear) begin
            count <= {`PS_WIDTH{1'b0}};
        end else if (osc_tick) begin
            // Compare with >= so a smaller ratio chosen mid-count cannot stall
            if (count >= last_count(select)) begin
                count <= {`PS_WIDTH{1'b0}};
            end else begin
                count <= count + 11'h001;
            end
        end
    end

endmodule

// file: design/self_wakeup_timer.v
`timescale 1ns/100ps
`include "wake_timer_consts.vh"

module self_wakeup_timer (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    // Low-speed oscillator
    input wire osc_in,
    output wire osc_keep_on,
    // Power modes
    input wire idle_mode,
    input wire power_down_mode,
    output reg wakeup,
    // Interrupts
    output wire wake_irq_request,
    output wire irq
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg wake_overflow_flag;
    reg wake_run_bit;
    reg [2:0] wake_prescale_select;
    reg [7:0] wake_reload_value;
    reg wake_irq_enable;
    reg global_irq_enable;
    reg [`EVT_WIDTH-1:0] event_status;
    reg [`EVT_WIDTH-1:0] event_mask;
    reg [7:0] wake_timer;
    reg run_prev;
    reg low_power_prev;

    // ----------------------------------------
    // Internal signals
    // ----------------------------------------
    wire osc_tick;
    wire ps_tick;
    wire run_start;
    wire overflow;
    wire low_power;
    wire wake_event;
    wire ps_clear;
    wire [7:0] control_value;
    reg [7:0] next_rdata;
    reg [`EVT_WIDTH-1:0] next_status;

    localparam [7:0] CONTROL_RESET = `RST_CONTROL;
    localparam [1:0] IRQ_CONTROL_RESET = `RST_IRQ_CONTROL;

    function hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            hit = (addr == offset);
        end
    endfunction

    // ----------------------------------------
    // Oscillator tick and prescaler
    // ----------------------------------------
    // The pin passes a three-flop synchronizer and a level must hold for two
    // samples to count; shorter levels are lost, hence the clock ratio demand.
    osc_edge_sync osc_edge_sync_inst (
        .sys_clk(sys_clk),
        .reset(reset),
        .osc_in(osc_in),
        .osc_tick(osc_tick)
    );

    assign ps_clear = ~wake_run_bit | run_start;

    wake_prescaler wake_prescaler_inst (
        .sys_clk(sys_clk),
        .reset(reset),
        .clear(ps_clear),
        .osc_tick(osc_tick),
        .select(wake_prescale_select),
        .ps_tick(ps_tick)
    );

    // ----------------------------------------
    // Control decode
    // ----------------------------------------
    assign run_start = wake_run_bit & ~run_prev;
    assign low_power = idle_mode | power_down_mode;
    // Only reset or clearing the run bit stops the counter; power modes do not
    // A stale count of FF left from the last run must not roll over at start
    assign overflow = wake_run_bit & ~run_start & ps_tick & (wake_timer == `COUNT_TOP);
    assign wake_event = overflow & low_power;
    // Software owns turning the oscillator on; this only stops it being
    // gated off while asleep
    assign osc_keep_on = wake_run_bit;

    assign control_value = {3'h0, wake_overflow_flag, wake_run_bit, wake_prescale_select};

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (reset) begin
            wake_run_bit <= CONTROL_RESET[`CTL_RUN_BIT];
            wake_prescale_select <= CONTROL_RESET[`CTL_PS_MSB:`CTL_PS_LSB];
        end else if (reg_write && hit(reg_addr, `OFF_CONTROL)) begin
            wake_run_bit <= reg_wdata[`CTL_RUN_BIT];
            wake_prescale_select <= reg_wdata[`CTL_PS_MSB:`CTL_PS_LSB];
        end
    end

    // Overflow wins over a clearing write in the same cycle
    always @(posedge sys_clk) begin
        if (reset) begin
            wake_overflow_flag <= 1'b0;
        end else if (overflow) begin
            wake_overflow_flag <= 1'b1;
        end else if (reg_write && hit(reg_addr, `OFF_CONTROL)) begin
            wake_overflow_flag <= reg_wdata[`CTL_FLAG_BIT];
        end
    end

    // ----------------------------------------
    // Reload register
    // ----------------------------------------
    // Writes while running are accepted as-is; the next reload may then
    // pick up either value, so software keeps to writing while halted.
    always @(posedge sys_clk) begin
        if (reset) begin
            wake_reload_value <= `RST_RELOAD;
        end else if (reg_write && hit(reg_addr, `OFF_RELOAD)) begin
            wake_reload_value <= reg_wdata;
        end
    end

    // ----------------------------------------
    // Interrupt enable register
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (reset) begin
            wake_irq_enable <= IRQ_CONTROL_RESET[`IEN_WAKE_BIT];
            global_irq_enable <= IRQ_CONTROL_RESET[`IEN_GLOBAL_BIT];
        end else if (reg_write && hit(reg_addr, `OFF_IRQ_CONTROL)) begin
            wake_irq_enable <= reg_wdata[`IEN_WAKE_BIT];
            global_irq_enable <= reg_wdata[`IEN_GLOBAL_BIT];
        end
    end

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (reset) begin
            run_prev <= 1'b0;
        end else begin
            run_prev <= wake_run_bit;
        end
    end

    // Counting ignores idle_mode and power_down_mode entirely
    always @(posedge sys_clk) begin
        if (reset) begin
            wake_timer <= `RST_COUNT;
        end else if (run_start) begin
            wake_timer <= wake_reload_value;
        end else if (wake_run_bit && ps_tick) begin
            if (wake_timer == `COUNT_TOP) begin
                wake_timer <= wake_reload_value;
            end else begin
                wake_timer <= wake_timer + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Wake-up
    // ----------------------------------------
    // Held from the overflow until the power mode is left, so a slow
    // power controller cannot miss it. Reload FFH at 1/1 overflows every
    // tick and is left to software to avoid.
    always @(posedge sys_clk) begin
        if (reset) begin
            wakeup <= 1'b0;
            low_power_prev <= 1'b0;
        end else begin
            low_power_prev <= low_power;
            if (!low_power) begin
                wakeup <= 1'b0;
            end else if (wake_event) begin
                wakeup <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    always @* begin
        next_status = event_status;
        if (reg_read && hit(reg_addr, `OFF_STATUS)) begin
            next_status = {`EVT_WIDTH{1'b0}};
        end
        if (overflow) begin
            next_status[`EVT_OVERFLOW_BIT] = 1'b1;
        end
        if (wake_event) begin
            next_status[`EVT_WAKEUP_BIT] = 1'b1;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            event_status <= `RST_STATUS;
        end else begin
            event_status <= next_status;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            event_mask <= `RST_MASK;
        end else if (reg_write && hit(reg_addr, `OFF_MASK)) begin
            event_mask <= reg_wdata[`EVT_WIDTH-1:0];
        end
    end

    assign irq = |(event_status & event_mask);
    assign wake_irq_request = wake_overflow_flag & wake_irq_enable & global_irq_enable;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always @* begin
        next_rdata = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                `OFF_CONTROL: next_rdata = control_value;
                `OFF_RELOAD: next_rdata = wake_reload_value;
                `OFF_IRQ_CONTROL: next_rdata = {6'h00, global_irq_enable, wake_irq_enable};
                `OFF_STATUS: next_rdata = {6'h00, event_status};
                `OFF_MASK: next_rdata = {6'h00, event_mask};
                `OFF_COUNT: next_rdata = wake_timer;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

// file: sim/self_wakeup_timer_monitor.sv
`timescale 1ns/100ps
module self_wakeup_timer_monitor (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_rdata,
    // Power mode inputs, oscillator hold and interrupt outputs
    input wire osc_keep_on,
    input wire idle_mode,
    input wire power_down_mode,
    input wire wakeup,
    input wire wake_irq_request,
    input wire irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    wire ctl_wr = reg_write && reg_addr == 8'h8F;
    wire ctl_rd = reg_read && reg_addr == 8'h8F;
    wire low_power = idle_mode || power_down_mode;

    AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_KEEP_ON_WRITE: assert property (ctl_wr |=> osc_keep_on == $past(reg_wdata[3]))
        else $error("oscillator hold does not follow run bit");
    AST_KEEP_ON_HOLD: assert property (!ctl_wr |=> $stable(osc_keep_on))
        else $error("run state changed without a control write");
    AST_CTL_RESERVED: assert property (ctl_rd |=> reg_rdata[7:5] == 3'h0)
        else $error("reserved control bits not zero");
    AST_CTL_RUN_READ: assert property (ctl_rd |=> reg_rdata[3] == $past(osc_keep_on))
        else $error("run bit readback wrong");
    AST_REQ_OFF: assert property (reg_write && reg_addr == 8'h90 && reg_wdata[1:0] != 2'h3 |=> !wake_irq_request)
        else $error("interrupt request without both enables");
    // Only software may drop the flag, so only a write can end the request
    AST_REQ_HOLD: assert property (wake_irq_request && !reg_write |=> wake_irq_request)
        else $error("overflow flag cleared by hardware");
    AST_WAKE_DROP: assert property (!low_power |=> !wakeup)
        else $error("wakeup high outside low power");
    AST_WAKE_HOLD: assert property (wakeup && low_power |=> wakeup)
        else $error("wakeup dropped during low power");
    AST_IRQ_HOLD: assert property (irq && !reg_write && !reg_read |=> irq)
        else $error("interrupt dropped without access");

    cover property ($rose(wakeup));
    cover property ($rose(wake_irq_request));
    cover property ($rose(irq) ##[1:20] !irq);
endmodule

bind self_wakeup_timer self_wakeup_timer_monitor self_wakeup_timer_monitor_inst (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .osc_keep_on(osc_keep_on),
    .idle_mode(idle_mode), .power_down_mode(power_down_mode), .wakeup(wakeup),
    .wake_irq_request(wake_irq_request), .irq(irq));

// file: sim/self_wakeup_timer_tb.sv
`timescale 1ns/100ps
`include "wake_timer_consts.vh"
module self_wakeup_timer_tb;
    reg sys_clk = 1'b0;
    reg reset = 1'b1;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_write = 1'b0;
    reg reg_read = 1'b0;
    reg osc_in = 1'b0;
    reg idle_mode = 1'b0;
    reg power_down_mode = 1'b0;
    wire [7:0] reg_rdata;
    wire osc_keep_on;
    wire wakeup;
    wire wake_irq_request;
    wire irq;
    integer err_count = 0;
    integer samples_checked = 0;
    integer cycles = 0;
    integer osc_cnt = 0;
    integer n;
    integer i;
    integer per;

    self_wakeup_timer self_wakeup_timer_inst (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .osc_in(osc_in), .osc_keep_on(osc_keep_on), .idle_mode(idle_mode),
        .power_down_mode(power_down_mode), .wakeup(wakeup), .wake_irq_request(wake_irq_request), .irq(irq));

    always #5 sys_clk = ~sys_clk;

    // ----------------------------------------
    // Oscillator and timeout
    // ----------------------------------------
    // Eight-clock oscillator period keeps the 1/2048 run short yet meets the two-to-one ratio
    // Oscillator runs steadily from time zero, so it is stable before any start
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        osc_cnt <= (osc_cnt == 3) ? 0 : osc_cnt + 1;
        if (osc_cnt == 3) osc_in <= ~osc_in;
        if (cycles == 80000) begin
            err_count = err_count + 1;
            results;
        end
    end

    // ----------------------------------------
    // Access and check tasks
    // ----------------------------------------
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task chk_bit(input b, input e);
        chk({7'h00, b}, {7'h00, e});
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_write <= 1'b1;
            @(posedge sys_clk);
            reg_write <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_read <= 1'b1;
            @(posedge sys_clk);
            reg_read <= 1'b0;
            #1 chk(reg_rdata, exp);
        end
    endtask
    task wait_irq(output integer cnt);
        begin
            cnt = 0;
            while (irq !== 1'b1 && cnt < 40000) begin
                @(posedge sys_clk);
                #1 cnt = cnt + 1;
            end
            if (cnt >= 40000) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t no interrupt before limit", $time);
            end
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        for (i = 0; i < 6; i = i + 1) rd(8'h8E + i[7:0], 8'h00);
        rd(`OFF_RELOAD, 8'h00);
        wr(8'h55, 8'hFF);
        rd(8'h55, 8'h00);
        wr(`OFF_RELOAD, 8'hA5);
        rd(`OFF_RELOAD, 8'hA5);
        wr(`OFF_CONTROL, 8'hE7);
        rd(`OFF_CONTROL, 8'h07);
        wr(`OFF_RELOAD, 8'h7F);
        wr(`OFF_CONTROL, 8'h0F);
        rd(`OFF_COUNT, 8'h7F);
        chk_bit(osc_keep_on, 1'b1);
        wr(`OFF_IRQ_CONTROL, 8'h03);
        wr(`OFF_MASK, 8'h01);
        // Halt first: the reload byte is only written while stopped
        wr(`OFF_CONTROL, 8'h07);
        wr(`OFF_RELOAD, 8'hFE);
        wr(`OFF_CONTROL, 8'h08);
        wait_irq(n);
        chk_bit(wake_irq_request, 1'b1);
        rd(`OFF_STATUS, 8'h01);
        chk_bit(irq, 1'b0);
        rd(`OFF_CONTROL, 8'h18);
        for (i = 0; i < 4; i = i + 1) begin
            wr(`OFF_IRQ_CONTROL, i[7:0]);
            #1 chk_bit(wake_irq_request, i == 3);
        end
        wr(`OFF_CONTROL, 8'h00);
        #1 chk_bit(wake_irq_request, 1'b0);
        // Halted two cycles before the next rollover was due
        rd(`OFF_STATUS, 8'h00);
        repeat (100) @(posedge sys_clk);
        rd(`OFF_STATUS, 8'h00);
        // Overflow interval per prescale; 1/1 avoids a reload of FF
        for (i = 0; i < 8; i = i + 1) begin
            per = 8 * ((i == 0) ? 2 : (i < 5) ? (1 << (2 * i)) : (1 << (i + 4)));
            wr(`OFF_RELOAD, (i == 0) ? 8'hFE : 8'hFF);
            wr(`OFF_CONTROL, 8'h08 | i[7:0]);
            wait_irq(n);
            rd(`OFF_STATUS, 8'h01);
            wait_irq(n);
            chk_bit((n + 2 >= per - 1) && (n + 2 <= per + 1), 1'b1);
            wr(`OFF_CONTROL, 8'h00);
            rd(`OFF_STATUS, 8'h01);
        end
        wr(`OFF_RELOAD, 8'hFE);
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge sys_clk);
            idle_mode <= (i == 0);
            power_down_mode <= (i == 1);
            wr(`OFF_CONTROL, 8'h08);
            wait_irq(n);
            #1 chk_bit(wakeup, 1'b1);
            chk_bit(osc_keep_on, 1'b1);
            rd(`OFF_STATUS, 8'h03);
            @(posedge sys_clk);
            idle_mode <= 1'b0;
            power_down_mode <= 1'b0;
            @(posedge sys_clk);
            #1 chk_bit(wakeup, 1'b0);
            wr(`OFF_CONTROL, 8'h00);
            // Stopped well before the next rollover, so nothing new is flagged
            rd(`OFF_STATUS, 8'h00);
        end
        results;
    end
endmodule
